// ### rtl/cspid_decoder.sv
// command decoder of a flash card in serial mode
// assumes the host drives sclk/cs_n/mosi and a user side that moves data blocks
`timescale 1ns/1ps
// Function
// (R1) six-bit index in plain binary
// (R2) host zeroes unused argument
// (R3) index 0 idles, 1 starts initialization
// (R4) index 9, 10 read data registers
// (R5) index 12 stops read, busy follows
// (R6) index 13 answers two status bytes
// (R7) index 16 sets block length
// (R8) writes need 512-byte length, else error
// (R9) read length 1 to 512 bytes
// (R10) block length 512 after reset
// (R11) index 17 reads one block
// (R12) host keeps reads inside physical block
// (R13) index 18 reads until stop
// (R14) index 24 writes one block, busy
// (R15) single write sector aligned, 512 bytes
// (R16) index 25 writes until stop token
// (R17) indices 2,3,4,7,11,14,15,20 unsupported
// (R18) indices 5,6,8,19,21-23 reserved
// (R19) six-byte frame, msb first
// (R20) seven-bit crc, x^7+x^3+1
// (R21) always answer, rejecting bad commands
// (R22) during read only stop accepted
// (R23) rejected command changes no state; a write rejected for bad length still sets write_err
module cspid_decoder (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   input wire logic busy_i,
   input wire logic rd_done_i,
   output logic op_valid_o,
   output cspid_pkg::cspid_op_t op_kind_o,
   output logic [31:0] op_arg_o,
   output logic [cspid_pkg::BLK_LEN_W-1:0] blk_len_o,
   output logic idle_o,
   output logic reading_o,
   output logic write_err_o
);
   logic frame_tgl;
   logic [5:0] frame_cmd;
   logic [31:0] frame_arg;
   logic frame_ok;
   logic ft_s1_r, ft_s2_r, ft_s3_r;
   logic [5:0] cmd_r;
   logic [31:0] arg_r;
   logic ok_r;
   cspid_pkg::cspid_state_t state_r, state_nxt;
   logic resp_tgl_r;
   logic [15:0] resp_r;
   logic resp_two_r;
   logic busy_r;
   logic [cspid_pkg::BLK_LEN_W-1:0] blk_len_r;
   logic idle_r, reading_r, write_err_r;

   cspid_link u_link (
      .sclk_i(sclk_i),
      .rst_i(rst_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .miso_o(miso_o),
      .miso_oe_o(miso_oe_o),
      .frame_tgl_o(frame_tgl),
      .frame_cmd_o(frame_cmd),
      .frame_arg_o(frame_arg),
      .frame_ok_o(frame_ok),
      .resp_tgl_i(resp_tgl_r),
      .resp_data_i(resp_r),
      .resp_two_i(resp_two_r),
      .busy_i(busy_r)
   );

   // frame arrival crosses as a toggle; fields are stable long before it lands
   always_ff @(posedge clk_i) begin
      ft_s1_r <= frame_tgl;
      ft_s2_r <= ft_s1_r;
      ft_s3_r <= ft_s2_r;
   end
   wire frame_new = ft_s2_r ^ ft_s3_r;

   // (R1) index compared in plain binary
   wire is_reset = cmd_r == cspid_pkg::CMD_RESET;
   wire is_init = cmd_r == cspid_pkg::CMD_INIT;
   wire is_csd = cmd_r == cspid_pkg::CMD_RD_SPECIFIC;
   wire is_cid = cmd_r == cspid_pkg::CMD_RD_IDENT;
   wire is_stop = cmd_r == cspid_pkg::CMD_STOP;
   wire is_status = cmd_r == cspid_pkg::CMD_STATUS;
   wire is_len = cmd_r == cspid_pkg::CMD_BLK_LEN;
   wire is_rd_one = cmd_r == cspid_pkg::CMD_RD_ONE;
   wire is_rd_multi = cmd_r == cspid_pkg::CMD_RD_MULTI;
   wire is_wr_one = cmd_r == cspid_pkg::CMD_WR_ONE;
   wire is_wr_multi = cmd_r == cspid_pkg::CMD_WR_MULTI;
   wire is_rd = is_rd_one | is_rd_multi;
   wire is_wr = is_wr_one | is_wr_multi;

   // (R17) unsupported indices fall outside known set
   // (R18) reserved indices fall outside known set
   wire known = is_reset | is_init | is_csd | is_cid | is_stop | is_status | is_len
      | is_rd | is_wr;

   // (R9) read length range
   wire len_ok = (arg_r != 32'h0000_0000) && (arg_r <= cspid_pkg::RD_LEN_MAX);
   // (R8) write length must be full block
   wire wr_len_bad = is_wr && (blk_len_r != cspid_pkg::WR_BLK_LEN);
   // (R15) sector alignment checked
   wire wr_addr_bad = is_wr && (arg_r[cspid_pkg::SECTOR_BITS-1:0] != '0);
   // (R22) only stop while reading
   wire rd_block = reading_r && !is_stop;

   // (R21) rejection causes
   wire err_illegal = !known | rd_block | busy_r;
   wire err_crc = !ok_r;
   wire err_param = (is_len && !len_ok) | wr_len_bad;
   wire err_addr = wr_addr_bad;
   wire reject = err_illegal | err_crc | err_param | err_addr;
   wire accept = !reject;

   // (R3) idle entered on reset, left on init
   wire idle_nxt = (accept && is_reset) ? 1'b1 : (accept && is_init) ? 1'b0 : idle_r;

   logic [7:0] r1_w;
   assign r1_w[cspid_pkg::R1_IDLE] = idle_nxt;
   assign r1_w[cspid_pkg::R1_ERASE_RST] = 1'b0;
   assign r1_w[cspid_pkg::R1_ILLEGAL] = err_illegal;
   assign r1_w[cspid_pkg::R1_CRC] = err_crc;
   assign r1_w[cspid_pkg::R1_ERASE_SEQ] = 1'b0;
   assign r1_w[cspid_pkg::R1_ADDR] = err_addr;
   assign r1_w[cspid_pkg::R1_PARAM] = err_param;
   assign r1_w[cspid_pkg::R1_START] = 1'b0;

   logic [7:0] st_w;
   assign st_w = 8'(write_err_r) << cspid_pkg::ST_WR_ERR;

   // operation handed to the user side
   cspid_pkg::cspid_op_t op_w;
   assign op_w = is_reset ? cspid_pkg::OP_RESET
      : is_init ? cspid_pkg::OP_INIT
      : is_csd ? cspid_pkg::OP_RD_SPECIFIC
      : is_cid ? cspid_pkg::OP_RD_IDENT
      : is_stop ? cspid_pkg::OP_STOP
      : is_rd_one ? cspid_pkg::OP_RD_ONE
      : is_rd_multi ? cspid_pkg::OP_RD_MULTI
      : is_wr_one ? cspid_pkg::OP_WR_ONE
      : is_wr_multi ? cspid_pkg::OP_WR_MULTI
      : cspid_pkg::OP_NONE;
   wire op_go = accept && (op_w != cspid_pkg::OP_NONE);
   wire exec = state_r == cspid_pkg::ST_EXEC;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cspid_pkg::ST_WAIT: begin
            if (frame_new) begin
               state_nxt = cspid_pkg::ST_EXEC;
            end
         end
         cspid_pkg::ST_EXEC: state_nxt = cspid_pkg::ST_REPLY;
         // extra step so every move flips one state bit
         cspid_pkg::ST_REPLY: state_nxt = cspid_pkg::ST_DONE;
         cspid_pkg::ST_DONE: state_nxt = cspid_pkg::ST_WAIT;
         default: state_nxt = cspid_pkg::ST_WAIT;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= cspid_pkg::ST_WAIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // capture the frame fields once the toggle has settled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_r <= 6'h00;
         arg_r <= 32'h0000_0000;
         ok_r <= 1'b0;
      end else if (frame_new && state_r == cspid_pkg::ST_WAIT) begin
         cmd_r <= frame_cmd;
         arg_r <= frame_arg;
         ok_r <= frame_ok;
      end
   end

   // (R6) status command answers two bytes
   // idle line reads ones, so a one-byte answer pads its low byte with ones
   wire two_byte = accept && is_status;
   wire [7:0] resp_lo = two_byte ? st_w : 8'hff;

   // (R21) every frame gets an answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resp_r <= 16'hffff;
         resp_two_r <= 1'b0;
         resp_tgl_r <= 1'b0;
      end else if (exec) begin
         resp_r <= {r1_w, resp_lo};
         resp_two_r <= two_byte;
      end else if (state_r == cspid_pkg::ST_REPLY) begin
         resp_tgl_r <= !resp_tgl_r;
      end
   end

   // (R23) state moves only on accept
   wire len_restore = exec && accept && is_reset;
   wire len_load = exec && accept && is_len;

   // (R10) default length after reset
   // (R7) accepted length taken from argument
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_len_r <= cspid_pkg::BLK_LEN_RST;
      end else if (len_restore) begin
         blk_len_r <= cspid_pkg::BLK_LEN_RST;
      end else if (len_load) begin
         // accepted lengths stay below 1024, so the low bits hold all of it
         blk_len_r <= arg_r[cspid_pkg::BLK_LEN_W-1:0];
      end
   end

   // (R13) multiple read runs until stop
   // (R5) stop ends the read
   wire rd_start = exec && accept && is_rd;
   wire rd_end = (exec && accept && (is_stop || is_reset)) || rd_done_i;

   // (R3) idle state tracking
   // (R11) single read marks read in progress
   // a new read wins over a late done pulse of the previous one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_r <= 1'b1;
         reading_r <= 1'b0;
      end else begin
         if (exec) begin
            idle_r <= idle_nxt;
         end
         if (rd_start) begin
            reading_r <= 1'b1;
         end else if (rd_end) begin
            reading_r <= 1'b0;
         end
      end
   end

   // (R8) write error kept until status read; a new error wins over the clear
   wire werr_set = exec && wr_len_bad;
   wire werr_clr = exec && accept && is_status;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_err_r <= 1'b0;
      end else if (werr_set) begin
         write_err_r <= 1'b1;
      end else if (werr_clr) begin
         write_err_r <= 1'b0;
      end
   end

   // (R4) register reads handed out
   // (R14) single write handed out
   // (R16) multiple write handed out
   wire issue = exec && op_go;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_valid_o <= 1'b0;
         op_kind_o <= cspid_pkg::OP_NONE;
         op_arg_o <= 32'h0000_0000;
      end else begin
         op_valid_o <= issue;
         if (issue) begin
            op_kind_o <= op_w;
            op_arg_o <= arg_r;
         end
      end
   end

   // (R5) busy shown on the line by user side level
   // (R14) programming busy shown the same way
   // one flop only: the user side shares this clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= busy_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_len_o <= cspid_pkg::BLK_LEN_RST;
         idle_o <= 1'b1;
         reading_o <= 1'b0;
         write_err_o <= 1'b0;
      end else begin
         blk_len_o <= blk_len_r;
         idle_o <= idle_r;
         reading_o <= reading_r;
         write_err_o <= write_err_r;
      end
   end
endmodule : cspid_decoder

// ### rtl/cspid_pkg.sv
// constants shared by the card serial command decoder and its link end
// assumes a 10 MHz core clock and a host-driven serial clock
package cspid_pkg;
   // frame layout, most significant bit first
   localparam int FRAME_BITS = 48;
   localparam logic [5:0] FRAME_LAST = 6'h2f;
   localparam logic [5:0] CRC_SPAN = 6'h28;
   localparam logic [6:0] CRC_POLY = 7'h09;
   localparam int POS_START = 47;
   localparam int POS_TXBIT = 46;
   localparam int POS_CMD_HI = 45;
   localparam int POS_CMD_LO = 40;
   localparam int POS_ARG_HI = 39;
   localparam int POS_ARG_LO = 8;
   localparam int POS_CRC_HI = 7;
   localparam int POS_CRC_LO = 1;
   localparam int POS_END = 0;

   // command indices in plain binary
   localparam logic [5:0] CMD_RESET = 6'h00;
   localparam logic [5:0] CMD_INIT = 6'h01;
   localparam logic [5:0] CMD_RD_SPECIFIC = 6'h09;
   localparam logic [5:0] CMD_RD_IDENT = 6'h0a;
   localparam logic [5:0] CMD_STOP = 6'h0c;
   localparam logic [5:0] CMD_STATUS = 6'h0d;
   localparam logic [5:0] CMD_BLK_LEN = 6'h10;
   localparam logic [5:0] CMD_RD_ONE = 6'h11;
   localparam logic [5:0] CMD_RD_MULTI = 6'h12;
   localparam logic [5:0] CMD_WR_ONE = 6'h18;
   localparam logic [5:0] CMD_WR_MULTI = 6'h19;

   // block length
   localparam int BLK_LEN_W = 10;
   localparam logic [BLK_LEN_W-1:0] BLK_LEN_RST = 10'h200;
   localparam logic [31:0] RD_LEN_MAX = 32'h0000_0200;
   localparam logic [BLK_LEN_W-1:0] WR_BLK_LEN = 10'h200;
   localparam int SECTOR_BITS = 9;

   // basic_response bit positions
   localparam int R1_IDLE = 0;
   localparam int R1_ERASE_RST = 1;
   localparam int R1_ILLEGAL = 2;
   localparam int R1_CRC = 3;
   localparam int R1_ERASE_SEQ = 4;
   localparam int R1_ADDR = 5;
   localparam int R1_PARAM = 6;
   localparam int R1_START = 7;
   // second byte of two_byte_status_response
   localparam int ST_WR_ERR = 0;

   localparam logic [4:0] TX_ONE = 5'h08;
   localparam logic [4:0] TX_TWO = 5'h10;

   typedef enum logic [3:0] {
      OP_RESET = 4'h0,
      OP_INIT = 4'h1,
      OP_RD_SPECIFIC = 4'h2,
      OP_RD_IDENT = 4'h3,
      OP_STOP = 4'h4,
      OP_RD_ONE = 4'h5,
      OP_RD_MULTI = 4'h6,
      OP_WR_ONE = 4'h7,
      OP_WR_MULTI = 4'h8,
      OP_NONE = 4'hf
   } cspid_op_t;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_EXEC = 2'b01,
      ST_REPLY = 2'b11,
      ST_DONE = 2'b10
   } cspid_state_t;
endpackage : cspid_pkg

// ### rtl/cspid_link.sv
// serial link end: frame receiver with crc check and response shifter
// runs on the host serial clock; crossings use toggles and two flops
`timescale 1ns/1ps
module cspid_link (
   input wire logic sclk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic frame_tgl_o,
   output logic [5:0] frame_cmd_o,
   output logic [31:0] frame_arg_o,
   output logic frame_ok_o,
   input wire logic resp_tgl_i,
   input wire logic [15:0] resp_data_i,
   input wire logic resp_two_i,
   input wire logic busy_i
);
   logic rst_s1_r, rst_s2_r;
   logic rs1_r, rs2_r, rs3_r;
   logic bs1_r, bs2_r;
   logic in_frame_r;
   logic [5:0] cnt_r;
   logic [46:0] sh_r;
   logic [6:0] crc_r;
   logic [15:0] tx_r;
   logic [4:0] tx_cnt_r;

   wire frame_rst = rst_s2_r | cs_n_i;
   wire begin_bit = !in_frame_r && !mosi_i;
   wire last_bit = in_frame_r && (cnt_r == cspid_pkg::FRAME_LAST);
   wire [47:0] full = {sh_r, mosi_i};
   wire crc_fb = mosi_i ^ crc_r[6];
   wire [6:0] crc_nxt = {crc_r[5:0], 1'b0} ^ (crc_fb ? cspid_pkg::CRC_POLY : 7'h00);
   wire in_crc_span = begin_bit || (in_frame_r && cnt_r < cspid_pkg::CRC_SPAN);
   // (R19) framing bits checked
   // (R20) remainder compared
   wire frame_ok = !full[cspid_pkg::POS_START] && full[cspid_pkg::POS_TXBIT]
      && full[cspid_pkg::POS_END]
      && full[cspid_pkg::POS_CRC_HI:cspid_pkg::POS_CRC_LO] == crc_r;
   wire resp_new = rs2_r ^ rs3_r;

   // reset comes from the core domain; catch it here with two flops
   always_ff @(posedge sclk_i) begin
      rst_s1_r <= rst_i;
      rst_s2_r <= rst_s1_r;
      rs1_r <= resp_tgl_i;
      rs2_r <= rs1_r;
      rs3_r <= rs2_r;
      bs1_r <= busy_i;
      bs2_r <= bs1_r;
   end

   // (R19) bit counting from start bit
   always_ff @(posedge sclk_i) begin
      if (frame_rst) begin
         in_frame_r <= 1'b0;
         cnt_r <= 6'h00;
      end else if (begin_bit) begin
         in_frame_r <= 1'b1;
         cnt_r <= 6'h01;
      end else if (last_bit) begin
         in_frame_r <= 1'b0;
         cnt_r <= 6'h00;
      end else if (in_frame_r) begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   // (R20) crc over first forty bits
   always_ff @(posedge sclk_i) begin
      if (frame_rst || last_bit) begin
         crc_r <= 7'h00;
      end else if (in_crc_span) begin
         crc_r <= crc_nxt;
      end
      sh_r <= {sh_r[45:0], mosi_i};
   end

   // fields stay put until the next frame; the core reads them after the toggle
   always_ff @(posedge sclk_i) begin
      if (rst_s2_r) begin
         frame_tgl_o <= 1'b0;
         frame_cmd_o <= 6'h00;
         frame_arg_o <= 32'h0000_0000;
         frame_ok_o <= 1'b0;
      end else if (last_bit && !cs_n_i) begin
         frame_tgl_o <= !frame_tgl_o;
         frame_cmd_o <= full[cspid_pkg::POS_CMD_HI:cspid_pkg::POS_CMD_LO];
         frame_arg_o <= full[cspid_pkg::POS_ARG_HI:cspid_pkg::POS_ARG_LO];
         frame_ok_o <= frame_ok;
      end
   end

   // idle line reads ones, busy reads zeros
   always_ff @(posedge sclk_i) begin
      if (rst_s2_r) begin
         tx_r <= 16'hffff;
         tx_cnt_r <= 5'h00;
         miso_o <= 1'b1;
         miso_oe_o <= 1'b0;
      end else begin
         miso_oe_o <= !cs_n_i;
         if (resp_new) begin
            tx_r <= resp_data_i;
            tx_cnt_r <= resp_two_i ? cspid_pkg::TX_TWO : cspid_pkg::TX_ONE;
            miso_o <= 1'b1;
         end else if (tx_cnt_r != 5'h00) begin
            miso_o <= tx_r[15];
            tx_r <= {tx_r[14:0], 1'b1};
            tx_cnt_r <= tx_cnt_r - 5'h01;
         end else begin
            miso_o <= !bs2_r;
         end
      end
   end
endmodule : cspid_link

// ### testbench/cspid_decoder_props.sv
// checker: decoder port relations over time
// assumes it is bound to cspid_decoder and sees its ports only
`timescale 1ns/1ps
module cspid_decoder_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic miso_oe_o,
   input wire logic op_valid_o,
   input wire cspid_pkg::cspid_op_t op_kind_o,
   input wire logic [cspid_pkg::BLK_LEN_W-1:0] blk_len_o,
   input wire logic idle_o,
   input wire logic reading_o,
   input wire logic write_err_o
);
   property p_rst_vals;
      @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |->
         blk_len_o == 10'h200 && idle_o && !reading_o && !write_err_o;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("bad state after reset");
   property p_rd_rise;
      @(posedge clk_i) disable iff (rst_i) op_valid_o && (op_kind_o == cspid_pkg::OP_RD_ONE
         || op_kind_o == cspid_pkg::OP_RD_MULTI) |=> reading_o;
   endproperty
   a_rd_rise: assert property (p_rd_rise) else $error("read not flagged");
   property p_stop;
      @(posedge clk_i) disable iff (rst_i)
         op_valid_o && op_kind_o == cspid_pkg::OP_STOP |-> ##[1:2] !reading_o;
   endproperty
   a_stop: assert property (p_stop) else $error("stop left read running");
   property p_rd_only_stop;
      @(posedge clk_i) disable iff (rst_i) reading_o && op_valid_o |->
         op_kind_o inside {cspid_pkg::OP_STOP, cspid_pkg::OP_RESET};
   endproperty
   a_rd_only_stop: assert property (p_rd_only_stop) else $error("op issued during read");
   property p_len_rng;
      @(posedge clk_i) disable iff (rst_i)
         $changed(blk_len_o) |-> blk_len_o != 10'h000 && blk_len_o <= 10'h200;
   endproperty
   a_len_rng: assert property (p_len_rng) else $error("length out of range");
   property p_wr_len;
      @(posedge clk_i) disable iff (rst_i) op_valid_o && op_kind_o inside
         {cspid_pkg::OP_WR_ONE, cspid_pkg::OP_WR_MULTI} |-> blk_len_o == 10'h200;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write with bad length");
   property p_werr;
      @(posedge clk_i) disable iff (rst_i) $rose(write_err_o) |-> blk_len_o != 10'h200;
   endproperty
   a_werr: assert property (p_werr) else $error("write error without cause");
   property p_init;
      @(posedge clk_i) disable iff (rst_i)
         op_valid_o && op_kind_o == cspid_pkg::OP_INIT |-> ##[0:2] !idle_o;
   endproperty
   a_init: assert property (p_init) else $error("idle kept after init");
   property p_go_idle;
      @(posedge clk_i) disable iff (rst_i) op_valid_o && op_kind_o == cspid_pkg::OP_RESET
         |-> ##[0:2] (idle_o && blk_len_o == 10'h200);
   endproperty
   a_go_idle: assert property (p_go_idle) else $error("reset op left state");
   property p_oe;
      @(posedge sclk_i) disable iff (rst_i) !cs_n_i [*2] |-> miso_oe_o;
   endproperty
   a_oe: assert property (p_oe) else $error("output not enabled");
endmodule : cspid_decoder_props

// ### testbench/cspid_host.sv
// host model: frames commands on the serial link, collects answers
// assumes answers start within 64 clocks; serial clock idles low
`timescale 1ns/1ps
module cspid_host (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b1;
   end
   // sample after the fall, card moves on the rise
   task tick(output logic s);
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
      s = miso_i;
   endtask : tick
   task dummy(input int n);
      logic s;
      repeat (n) tick(s);
   endtask : dummy
   function automatic logic [6:0] crc7(input logic [39:0] m);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction : crc7
   task xfer(input logic [5:0] c, input logic [31:0] a, input logic bad,
      output logic [15:0] r);
      logic [47:0] f;
      logic s;
      int k;
      f = {2'b01, c, a, crc7({2'b01, c, a}) ^ {6'h00, bad}, 1'b1};
      k = 0;
      cs_n_o = 1'b0;
      for (int i = 47; i >= 0; i--) begin
         mosi_o = f[i];
         tick(s);
      end
      mosi_o = 1'b1;
      s = 1'b1;
      while (s && k < 64) begin
         tick(s);
         k++;
      end
      r[15] = s;
      for (int j = 14; j >= 0; j--) begin
         tick(s);
         r[j] = s;
      end
      cs_n_o = 1'b1;
      // released line must not keep its last value
      mosi_o = ~mosi_o;
      // trailing clocks run deselected, so the card sees the release
      dummy(8);
   endtask : xfer
endmodule : cspid_host

// ### testbench/cspid_decoder_tb.sv
// bench: decoder driven by the host model and user-side inputs
// assumes 10 MHz core clock and a 30 ns serial clock inside frames
`timescale 1ns/1ps
module cspid_decoder_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic busy_i = 1'b0;
   logic rd_done_i = 1'b0;
   logic sclk, cs_n, mosi, miso, miso_oe, op_valid, idle, reading, write_err;
   cspid_pkg::cspid_op_t op_kind;
   logic [31:0] op_arg;
   logic [cspid_pkg::BLK_LEN_W-1:0] blk_len;
   wire logic miso_w;
   int mismatches = 0;
   int n_compared = 0;
   int n_ops = 0;
   logic [5:0] bad_ids [16] = '{6'h02, 6'h03, 6'h04, 6'h07, 6'h0b, 6'h0e, 6'h0f, 6'h14,
      6'h05, 6'h06, 6'h08, 6'h13, 6'h15, 6'h16, 6'h17, 6'h27};
   always #50 clk_i = ~clk_i;
   // pull-up on the released answer line
   assign miso_w = miso_oe ? miso : 1'b1;
   always @(posedge clk_i) if (op_valid === 1'b1) n_ops <= n_ops + 1;
   cspid_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .busy_i(busy_i),
      .rd_done_i(rd_done_i), .op_valid_o(op_valid), .op_kind_o(op_kind), .op_arg_o(op_arg),
      .blk_len_o(blk_len), .idle_o(idle), .reading_o(reading), .write_err_o(write_err));
   cspid_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cmd(input logic [5:0] c, input logic [31:0] a, input logic bad,
      input logic [15:0] er, input cspid_pkg::cspid_op_t k);
      int n0;
      logic [15:0] r;
      n0 = n_ops;
      host_u.xfer(c, a, bad, r);
      chk({16'h0, r}, {16'h0, er});
      chk(32'(n_ops - n0), {31'h0, k != cspid_pkg::OP_NONE});
      if (k != cspid_pkg::OP_NONE) begin
         chk({28'h0, op_kind}, {28'h0, k});
         chk(op_arg, a);
      end
   endtask : cmd
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task t_basic;
      chk({14'h0, blk_len, idle, reading, write_err, miso_oe, op_kind},
         {14'h0, 10'h200, 4'h8, 4'hf});
      cmd(6'h00, 32'h0, 1'b0, 16'h01ff, cspid_pkg::OP_RESET);
      cmd(6'h01, 32'h0, 1'b0, 16'h00ff, cspid_pkg::OP_INIT);
      chk({31'h0, idle}, 32'h0);
      cmd(6'h09, 32'h0, 1'b0, 16'h00ff, cspid_pkg::OP_RD_SPECIFIC);
      cmd(6'h0a, 32'h0, 1'b0, 16'h00ff, cspid_pkg::OP_RD_IDENT);
      $display("t_basic done");
   endtask : t_basic
   task t_len_write;
      cmd(6'h10, 32'h0, 1'b0, 16'h40ff, cspid_pkg::OP_NONE);
      cmd(6'h10, 32'h201, 1'b0, 16'h40ff, cspid_pkg::OP_NONE);
      chk({22'h0, blk_len}, 32'h200);
      cmd(6'h10, 32'h1, 1'b0, 16'h00ff, cspid_pkg::OP_NONE);
      chk({22'h0, blk_len}, 32'h1);
      cmd(6'h18, 32'h400, 1'b0, 16'h40ff, cspid_pkg::OP_NONE);
      chk({31'h0, write_err}, 32'h1);
      cmd(6'h0d, 32'h0, 1'b0, 16'h0001, cspid_pkg::OP_NONE);
      chk({31'h0, write_err}, 32'h0);
      cmd(6'h10, 32'h200, 1'b0, 16'h00ff, cspid_pkg::OP_NONE);
      cmd(6'h18, 32'h400, 1'b0, 16'h00ff, cspid_pkg::OP_WR_ONE);
      cmd(6'h18, 32'h100, 1'b0, 16'h20ff, cspid_pkg::OP_NONE);
      cmd(6'h19, 32'h600, 1'b0, 16'h00ff, cspid_pkg::OP_WR_MULTI);
      cmd(6'h0d, 32'h0, 1'b0, 16'h0000, cspid_pkg::OP_NONE);
      $display("t_len_write done");
   endtask : t_len_write
   task t_read;
      cmd(6'h12, 32'h800, 1'b0, 16'h00ff, cspid_pkg::OP_RD_MULTI);
      chk({31'h0, reading}, 32'h1);
      cmd(6'h11, 32'h0, 1'b0, 16'h04ff, cspid_pkg::OP_NONE);
      cmd(6'h10, 32'h8, 1'b0, 16'h04ff, cspid_pkg::OP_NONE);
      chk({22'h0, blk_len}, 32'h200);
      cmd(6'h0c, 32'h0, 1'b0, 16'h00ff, cspid_pkg::OP_STOP);
      chk({31'h0, reading}, 32'h0);
      cmd(6'h11, 32'h1000, 1'b0, 16'h00ff, cspid_pkg::OP_RD_ONE);
      chk({31'h0, reading}, 32'h1);
      @(posedge clk_i) rd_done_i <= 1'b1;
      @(posedge clk_i) rd_done_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, reading}, 32'h0);
      $display("t_read done");
   endtask : t_read
   task t_refuse;
      logic [15:0] r;
      int n0;
      for (int i = 0; i < 16; i++) begin
         cmd(bad_ids[i], 32'h0, 1'b0, 16'h04ff, cspid_pkg::OP_NONE);
      end
      cmd(6'h09, 32'h0, 1'b1, 16'h08ff, cspid_pkg::OP_NONE);
      @(posedge clk_i) busy_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      n0 = n_ops;
      host_u.xfer(6'h11, 32'h0, 1'b0, r);
      chk(32'(n_ops - n0), 32'h0);
      chk({31'h0, reading}, 32'h0);
      @(posedge clk_i) busy_i <= 1'b0;
      $display("t_refuse done");
   endtask : t_refuse
   initial begin
      fork
         host_u.dummy(8);
         repeat (4) @(posedge clk_i);
      join
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      host_u.dummy(4);
      t_basic();
      t_len_write();
      t_read();
      t_refuse();
      tally_and_finish();
   end
   initial begin
      #1000000;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule : cspid_decoder_tb
bind cspid_decoder cspid_decoder_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .miso_oe_o(miso_oe_o), .op_valid_o(op_valid_o), .op_kind_o(op_kind_o),
   .blk_len_o(blk_len_o), .idle_o(idle_o), .reading_o(reading_o), .write_err_o(write_err_o));
